// File: hw/sla_defines.svh
`ifndef SLA_DEFINES_SVH
`define SLA_DEFINES_SVH

// short direct window and fixed page
`define SLA_SADDR_LO 16'hFE20
`define SLA_SADDR_HI 16'hFF1F
`define SLA_PAGE_HI 8'hFE
// flag vector bit positions
`define SLA_FLAG_ZERO 2
`define SLA_FLAG_HALF 1
`define SLA_FLAG_CARRY 0
`define SLA_FLAGS_RST 3'h0
`define SLA_DATA_RST 8'h00

`endif

// File: hw/sla_pkg.sv
package sla_pkg;

    typedef enum logic [1:0] {
        SLA_OP_SUB = 2'h0,
        SLA_OP_SUBB = 2'h1,
        SLA_OP_AND = 2'h3
    } sla_op_e;

    // operand addressing forms
    typedef enum logic [2:0] {
        SLA_SRC_IMM = 3'h0,
        SLA_SRC_SADDR = 3'h1,
        SLA_SRC_SFR = 3'h2,
        SLA_SRC_REG = 3'h3,
        SLA_SRC_PAGE = 3'h4,
        SLA_SRC_PTR1 = 3'h5,
        SLA_SRC_PTR2 = 3'h6,
        SLA_SRC_INDEX = 3'h7
    } sla_src_e;

    // where the result goes
    typedef enum logic [1:0] {
        SLA_DST_ACC = 2'h0,
        SLA_DST_SADDR = 2'h1,
        SLA_DST_SFR = 2'h2,
        SLA_DST_REG = 2'h3
    } sla_dst_e;

    typedef struct packed {
        sla_op_e op;
        sla_src_e src;
        sla_dst_e dst;
        logic [2:0] dstReg;
        logic [2:0] srcReg;
        logic [7:0] imm8;
        logic [15:0] imm16;
        logic [7:0] sfrAddr;
    } sla_cmd_s;

    typedef struct packed {
        logic zero;
        logic halfBorrow;
        logic borrowCarry;
    } sla_flags_s;

    typedef enum logic [1:0] {
        SLA_ST_IDLE = 2'b00,
        SLA_ST_READ = 2'b01,
        SLA_ST_WRITE = 2'b11
    } sla_state_e;

endpackage : sla_pkg

// File: hw/sla_alu.sv
`timescale 1ns/1ps
`include "sla_defines.svh"
// Summary of operation
// - sub A,[pointer_pair_one]: A minus addressed byte into A.
// - sub A,[pointer_pair_two]: A minus byte into A, borrow flag.
// - subtract forms set carry on borrow out of bit 7, else clear.
// - subtract-with-borrow immediate: A minus imm minus carry into A.
// - short direct byte in FE20H-FF1FH; result written back there.
// - page-indirect address is FEH high byte, register low byte.
// - indexed address is 16-bit immediate base plus 8-bit register.
// - subtract-with-borrow sfr,imm: sfr minus imm minus carry.
// - register pair form: r minus r' minus carry into r.
// - subtract-with-borrow into A accepts every memory and sfr source.
// - AND immediate: A and imm into A.
// - AND short direct,imm: read byte, AND imm, write same byte.
// - AND sfr,imm: result written back to that sfr.
// - AND register pair: result into first register.
// - AND into A accepts short direct, sfr, page and pointer sources.
module sla_alu
    import sla_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // instruction from decoder
    input wire logic cmdValid,
    input wire sla_cmd_s cmd,
    // register file state
    input wire logic [7:0] accIn,
    input wire logic [7:0] regIn [0:7],
    input wire logic [15:0] pointerPairOne,
    input wire logic [15:0] pointerPairTwo,
    input wire sla_flags_s flagsIn,
    // memory and sfr bus, read data valid one cycle after request
    input wire logic [7:0] memRdata,
    input wire logic [7:0] sfrRdata,
    output logic memRd,
    output logic memWr,
    output logic [15:0] memAddr,
    output logic [7:0] memWdata,
    output logic sfrRd,
    output logic sfrWr,
    output logic [7:0] sfrAddrOut,
    output logic [7:0] sfrWdata,
    // register file writeback
    output logic accWe,
    output logic [7:0] accOut,
    output logic regWe,
    output logic [2:0] regWaddr,
    output logic [7:0] regWdata,
    output logic flagsWe,
    output sla_flags_s flagsOut,
    output logic busy,
    output logic done,
    output logic addrError
);

    function automatic logic [9:0] sla_sub(input logic [7:0] a,
            input logic [7:0] b, input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        sla_sub = {low[4], full[8], full[7:0]};
    endfunction : sla_sub

    function automatic logic is_mem(input sla_src_e s);
        is_mem = (s == SLA_SRC_SADDR) || (s >= SLA_SRC_PAGE);
    endfunction : is_mem

    sla_state_e state_r;
    sla_cmd_s cmd_r;
    logic [7:0] dstVal;
    logic [7:0] srcVal;
    logic [9:0] subRes;
    logic [7:0] result;
    logic [15:0] srcAddr;
    logic saddrOk;
    sla_flags_s flagsNxt;
    logic dstMem;
    logic needRd;

    // operand address for the memory source forms
    always_comb begin
        case (cmd.src)
            SLA_SRC_PAGE:
                srcAddr = {`SLA_PAGE_HI, regIn[cmd.srcReg]};
            SLA_SRC_PTR1: srcAddr = pointerPairOne;
            SLA_SRC_PTR2: srcAddr = pointerPairTwo;
            SLA_SRC_INDEX:
                srcAddr = cmd.imm16 + {8'h00, regIn[cmd.srcReg]};
            default: srcAddr = cmd.imm16;
        endcase
    end

    assign dstMem = (cmd.dst == SLA_DST_SADDR);
    assign needRd = is_mem(cmd.src) || dstMem || (cmd.dst == SLA_DST_SFR)
        || (cmd.src == SLA_SRC_SFR);
    assign saddrOk = (cmd.imm16 >= `SLA_SADDR_LO)
        && (cmd.imm16 <= `SLA_SADDR_HI);

    // operands once the read data is back
    always_comb begin
        case (cmd_r.dst)
            SLA_DST_SADDR: dstVal = memRdata;
            SLA_DST_SFR: dstVal = sfrRdata;
            SLA_DST_REG: dstVal = regIn[cmd_r.dstReg];
            default: dstVal = accIn;
        endcase
        case (cmd_r.src)
            SLA_SRC_IMM: srcVal = cmd_r.imm8;
            SLA_SRC_SFR: srcVal = sfrRdata;
            SLA_SRC_REG: srcVal = regIn[cmd_r.srcReg];
            default: srcVal = memRdata;
        endcase
    end

    // a borrow-aware subtract; plain subtract ignores incoming carry
    assign subRes = sla_sub(dstVal, srcVal,
        (cmd_r.op == SLA_OP_SUBB) && flagsIn.borrowCarry);
    assign result = (cmd_r.op == SLA_OP_AND) ? (dstVal & srcVal)
        : subRes[7:0];

    always_comb begin
        flagsNxt = flagsIn;
        flagsNxt.zero = (result == 8'h00);
        if (cmd_r.op != SLA_OP_AND) begin
            flagsNxt.halfBorrow = subRes[9];
            flagsNxt.borrowCarry = subRes[8];
        end
    end

    // sequencing: idle, read operands, write result
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SLA_ST_IDLE;
            cmd_r <= '0;
        end else if (clkEn) begin
            case (state_r)
                SLA_ST_IDLE: begin
                    if (cmdValid && !(dstMem && !saddrOk)) begin
                        cmd_r <= cmd;
                        state_r <= needRd ? SLA_ST_READ : SLA_ST_WRITE;
                    end
                end
                SLA_ST_READ: state_r <= SLA_ST_WRITE;
                SLA_ST_WRITE: state_r <= SLA_ST_IDLE;
                default: state_r <= SLA_ST_IDLE;
            endcase
        end
    end

    // bus requests: read in the cycle after acceptance, write back at end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memRd <= 1'b0;
            memWr <= 1'b0;
            memAddr <= 16'h0000;
            memWdata <= `SLA_DATA_RST;
            sfrRd <= 1'b0;
            sfrWr <= 1'b0;
            sfrAddrOut <= `SLA_DATA_RST;
            sfrWdata <= `SLA_DATA_RST;
        end else if (clkEn) begin
            memRd <= 1'b0;
            memWr <= 1'b0;
            sfrRd <= 1'b0;
            sfrWr <= 1'b0;
            if (state_r == SLA_ST_IDLE && cmdValid
                    && !(dstMem && !saddrOk) && needRd) begin
                memRd <= is_mem(cmd.src) || dstMem;
                memAddr <= dstMem ? cmd.imm16 : srcAddr;
                sfrRd <= (cmd.dst == SLA_DST_SFR) || (cmd.src == SLA_SRC_SFR);
                sfrAddrOut <= cmd.sfrAddr;
            end
            if (state_r == SLA_ST_WRITE) begin
                memWr <= (cmd_r.dst == SLA_DST_SADDR);
                memAddr <= cmd_r.imm16;
                memWdata <= result;
                sfrWr <= (cmd_r.dst == SLA_DST_SFR);
                sfrAddrOut <= cmd_r.sfrAddr;
                sfrWdata <= result;
            end
        end
    end

    // register file writeback and flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            accWe <= 1'b0;
            accOut <= `SLA_DATA_RST;
            regWe <= 1'b0;
            regWaddr <= 3'h0;
            regWdata <= `SLA_DATA_RST;
            flagsWe <= 1'b0;
            flagsOut <= `SLA_FLAGS_RST;
            done <= 1'b0;
        end else if (clkEn) begin
            accWe <= 1'b0;
            regWe <= 1'b0;
            flagsWe <= 1'b0;
            done <= 1'b0;
            if (state_r == SLA_ST_WRITE) begin
                accWe <= (cmd_r.dst == SLA_DST_ACC);
                accOut <= result;
                regWe <= (cmd_r.dst == SLA_DST_REG);
                regWaddr <= cmd_r.dstReg;
                regWdata <= result;
                flagsWe <= 1'b1;
                flagsOut <= flagsNxt;
                done <= 1'b1;
            end
        end
    end

    // busy and short direct range check
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            addrError <= 1'b0;
        end else if (clkEn) begin
            addrError <= (state_r == SLA_ST_IDLE) && cmdValid && dstMem
                && !saddrOk;
            if (state_r == SLA_ST_IDLE)
                busy <= cmdValid && !(dstMem && !saddrOk);
            else if (state_r == SLA_ST_WRITE)
                busy <= 1'b0;
        end
    end

endmodule : sla_alu

// File: tb/sla_alu_sva.sv
`timescale 1ns/1ps
module sla_alu_sva
    import sla_pkg::*;
(
    // clock and command
    input logic core_clk,
    input logic rst_n,
    input logic clkEn,
    input logic cmdValid,
    input sla_cmd_s cmd,
    input logic [7:0] regIn [0:7],
    input sla_flags_s flagsIn,
    // results
    input logic memRd,
    input logic memWr,
    input logic [15:0] memAddr,
    input logic accWe,
    input logic [7:0] accOut,
    input logic regWe,
    input logic flagsWe,
    input sla_flags_s flagsOut,
    input logic busy,
    input logic done,
    input logic addrError
);
    default clocking @(posedge core_clk); endclocking
    // a frozen enable stretches every latency, so attempts are dropped then
    default disable iff (!rst_n || !clkEn);
    logic take;
    assign take = cmdValid && !busy;
    sequence finish2;
        ##2 done && flagsWe;
    endsequence
    reg_form_a: assert property (take && cmd.src == SLA_SRC_REG
        |-> finish2 ##0 regWe) else $error("register form late");
    read_walk_a: assert property (memRd |-> finish2)
        else $error("read form late");
    rmw_window_a: assert property (memWr |-> $past(memRd, 2)
        && memAddr >= 16'hFE20 && memAddr <= 16'hFF1F)
        else $error("write outside window");
    page_addr_a: assert property (memRd && cmd.src == SLA_SRC_PAGE
        |-> memAddr == {8'hFE, regIn[cmd.srcReg]})
        else $error("page address wrong");
    index_addr_a: assert property (memRd && cmd.src == SLA_SRC_INDEX
        |-> memAddr == cmd.imm16 + {8'h00, regIn[cmd.srcReg]})
        else $error("index address wrong");
    and_flags_a: assert property (done && cmd.op == SLA_OP_AND
        |-> flagsOut[1:0] == flagsIn[1:0]) else $error("and moved carry");
    zero_flag_a: assert property (done && accWe
        |-> flagsOut.zero == (accOut == 8'h00)) else $error("zero wrong");
    window_refuse_a: assert property (take
        && cmd.dst == SLA_DST_SADDR
        && (cmd.imm16 < 16'hFE20 || cmd.imm16 > 16'hFF1F)
        |=> addrError && !busy) else $error("window not refused");
endmodule : sla_alu_sva

bind sla_alu sla_alu_sva u_sla_alu_sva (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .cmdValid(cmdValid),
    .cmd(cmd),
    .regIn(regIn),
    .flagsIn(flagsIn),
    .memRd(memRd),
    .memWr(memWr),
    .memAddr(memAddr),
    .accWe(accWe),
    .accOut(accOut),
    .regWe(regWe),
    .flagsWe(flagsWe),
    .flagsOut(flagsOut),
    .busy(busy),
    .done(done),
    .addrError(addrError)
);

// File: tb/sla_alu_tb.sv
`timescale 1ns/1ps
module sla_alu_tb;
    import sla_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    // enable is dropped only inside the freeze scenario
    logic clkEn = 1'b1;
    logic cmdValid = 1'b0;
    sla_cmd_s cmd = '0;
    sla_op_e op = SLA_OP_SUB;
    logic [7:0] accIn = 8'h00;
    logic [7:0] regIn [0:7] = '{8'h11, 8'h22, 8'h80, 8'h33, 8'h44, 8'h7F,
        8'h55, 8'h66};
    logic [15:0] pointerPairOne = 16'h1234, pointerPairTwo = 16'hABCD;
    logic [15:0] base = 16'hFE40, ad;
    sla_flags_s flagsIn = '0, flagsOut;
    logic [7:0] memRdata = 8'h00, sfrRdata = 8'h00;
    logic memRd, memWr, sfrRd, sfrWr, accWe, regWe, flagsWe, busy, done;
    logic addrError;
    logic [15:0] memAddr;
    logic [7:0] memWdata, sfrAddrOut, sfrWdata, accOut, regWdata;
    logic [2:0] regWaddr;
    int badCount = 0, samplesChecked = 0;

    sla_alu u_sla_alu (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .cmdValid(cmdValid),
        .cmd(cmd),
        .accIn(accIn),
        .regIn(regIn),
        .pointerPairOne(pointerPairOne),
        .pointerPairTwo(pointerPairTwo),
        .flagsIn(flagsIn),
        .memRdata(memRdata),
        .sfrRdata(sfrRdata),
        .memRd(memRd),
        .memWr(memWr),
        .memAddr(memAddr),
        .memWdata(memWdata),
        .sfrRd(sfrRd),
        .sfrWr(sfrWr),
        .sfrAddrOut(sfrAddrOut),
        .sfrWdata(sfrWdata),
        .accWe(accWe),
        .accOut(accOut),
        .regWe(regWe),
        .regWaddr(regWaddr),
        .regWdata(regWdata),
        .flagsWe(flagsWe),
        .flagsOut(flagsOut),
        .busy(busy),
        .done(done),
        .addrError(addrError)
    );

    always #10 core_clk = ~core_clk;

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            badCount++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic wrapUp;
        if (badCount == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrapUp

    // cmd is held past the done edge so the checker sees the right opcode
    task automatic run(sla_src_e s, sla_dst_e d, logic [7:0] rd,
        logic [7:0] er, logic [2:0] ef, logic [3:0] ew);
        int n;
        logic [1:0] rs;
        logic [1:0] exR;
        logic [3:0] exN;
        // memory read for memory sources or a short direct destination
        exR = {(s inside {SLA_SRC_SADDR, SLA_SRC_PAGE, SLA_SRC_PTR1,
            SLA_SRC_PTR2, SLA_SRC_INDEX}) || d == SLA_DST_SADDR,
            s == SLA_SRC_SFR || d == SLA_DST_SFR};
        exN = (exR != 2'h0) ? 4'h2 : 4'h1;
        rs = 2'h0;
        n = 0;
        cmd = '{op, s, d, 3'h2, 3'h5, 8'h0F, base, 8'h21};
        memRdata = rd;
        sfrRdata = rd;
        ad = 16'h0000;
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
        while (n < 6 && done !== 1'b1) begin
            if (memRd === 1'b1) ad = memAddr;
            rs = rs | {memRd === 1'b1, sfrRd === 1'b1};
            n++;
            @(negedge core_clk);
        end
        chk("reads_cycles", {exR, exN}, {rs, n[3:0]});
        chk("result", er, accWe ? accOut : regWe ? regWdata :
            memWr ? memWdata : sfrWdata);
        chk("flags_we", {ef, ew}, {flagsOut, accWe, regWe, memWr, sfrWr});
        @(negedge core_clk);
    endtask : run

    task automatic srcLoop(logic [7:0] er, logic [2:0] ef);
        sla_src_e s [6] = '{SLA_SRC_SADDR, SLA_SRC_SFR, SLA_SRC_PAGE,
            SLA_SRC_PTR1, SLA_SRC_PTR2, SLA_SRC_INDEX};
        logic [15:0] a [6] = '{16'hFE40, 16'h0000, 16'hFE7F, 16'h1234,
            16'hABCD, 16'hFEBF};
        for (int i = 0; i < 6; i++) begin
            run(s[i], SLA_DST_ACC, 8'h10, er, ef, 4'h8);
            chk("addr", a[i], ad);
        end
    endtask : srcLoop

    task automatic subPtr;
        op = SLA_OP_SUB;
        flagsIn = 3'h1;
        accIn = 8'h10;
        run(SLA_SRC_PTR1, SLA_DST_ACC, 8'h20, 8'hF0, 3'h1, 4'h8);
        chk("addr", 16'h1234, ad);
        run(SLA_SRC_PTR2, SLA_DST_ACC, 8'h20, 8'hF0, 3'h1, 4'h8);
        chk("addr", 16'hABCD, ad);
    endtask : subPtr

    task automatic subcForms;
        op = SLA_OP_SUBB;
        run(SLA_SRC_IMM, SLA_DST_ACC, 8'h00, 8'h00, 3'h6, 4'h8);
        run(SLA_SRC_IMM, SLA_DST_SFR, 8'h05, 8'hF5, 3'h3, 4'h1);
        run(SLA_SRC_REG, SLA_DST_REG, 8'h00, 8'h00, 3'h6, 4'h4);
        run(SLA_SRC_IMM, SLA_DST_SADDR, 8'h10, 8'h00, 3'h6, 4'h2);
        chk("addr", 16'hFE40, ad);
        flagsIn = 3'h0;
        accIn = 8'h0F;
        run(SLA_SRC_IMM, SLA_DST_ACC, 8'h00, 8'h00, 3'h4, 4'h8);
        flagsIn = 3'h1;
        accIn = 8'h40;
        srcLoop(8'h2F, 3'h2);
    endtask : subcForms

    task automatic andForms;
        op = SLA_OP_AND;
        flagsIn = 3'h3;
        accIn = 8'hF0;
        run(SLA_SRC_IMM, SLA_DST_ACC, 8'h00, 8'h00, 3'h7, 4'h8);
        run(SLA_SRC_IMM, SLA_DST_SFR, 8'hAA, 8'h0A, 3'h3, 4'h1);
        run(SLA_SRC_REG, SLA_DST_REG, 8'h00, 8'h00, 3'h7, 4'h4);
        base = 16'hFF1F;
        run(SLA_SRC_IMM, SLA_DST_SADDR, 8'h3C, 8'h0C, 3'h3, 4'h2);
        chk("addr", 16'hFF1F, ad);
        base = 16'hFE40;
        srcLoop(8'h10, 3'h3);
    endtask : andForms

    // enable low must hold the command mid-flight, then finish it unchanged
    task automatic freeze;
        op = SLA_OP_SUB;
        flagsIn = 3'h0;
        accIn = 8'h30;
        cmd = '{op, SLA_SRC_IMM, SLA_DST_ACC, 3'h2, 3'h5, 8'h0F, base,
            8'h21};
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
        clkEn = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("frozen", 16'h4, {busy, done, accWe});
        clkEn = 1'b1;
        @(negedge core_clk);
        chk("thawed", 16'h90A, {done, accOut, flagsOut});
        @(negedge core_clk);
    endtask : freeze

    task automatic refuse(logic [15:0] b);
        cmd = '{SLA_OP_AND, SLA_SRC_IMM, SLA_DST_SADDR, 3'h2, 3'h5, 8'h0F, b,
            8'h21};
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
        chk("addrError", 16'h1, addrError);
        @(negedge core_clk);
    endtask : refuse

    initial begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        subPtr();
        subcForms();
        andForms();
        freeze();
        refuse(16'hFF20);
        refuse(16'hFE1F);
        wrapUp();
    end

    // traffic needs about 100 cycles; this leaves a wide margin
    initial begin
        #20us;
        badCount++;
        wrapUp();
    end
endmodule : sla_alu_tb
